/* File: chg_pkg.sv */
`default_nettype none

package chg_pkg;

    // Register offsets
    localparam logic [7:0] CTRL1_OFS = 8'h20;
    localparam logic [7:0] VOLT_CFG_OFS = 8'h21;
    localparam logic [7:0] CURR_CFG_OFS = 8'h22;
    localparam logic [7:0] EVT_FLAGS_OFS = 8'h24;
    localparam logic [7:0] EVT_MASKS_OFS = 8'h25;
    localparam logic [7:0] STATE_RPT_OFS = 8'h26;

    // Values after reset
    localparam logic [7:0] CTRL1_RST = 8'h18;
    localparam logic [7:0] VOLT_CFG_RST = 8'h1a;
    localparam logic [7:0] CURR_CFG_RST = 8'hd5;
    localparam logic [5:0] EVT_MASKS_RST = 6'h00;

    // Field positions
    localparam int FORCE_DIS_BIT = 7;
    localparam int ENABLE_OVR_BIT = 4;
    localparam int FAST_EN_BIT = 3;
    localparam int FAST_TMR_LSB = 0;
    localparam int CV_SEL_LSB = 0;
    localparam int OVP_LSB = 6;
    localparam int AUTO_OFF_BIT = 5;
    localparam int RANGE_BIT = 4;
    localparam int ISEL_LSB = 0;
    localparam int FAULT_EVT = 5;
    localparam int DONE_EVT = 4;
    localparam int CV_EVT = 3;
    localparam int FAST_EVT = 2;
    localparam int PRE_EVT = 1;
    localparam int IDLE_EVT = 0;
    localparam int FAST_EXPIRED_BIT = 7;
    localparam int PRE_EXPIRED_BIT = 6;
    localparam int NUM_EVT = 6;

    // Analog set points in mV and mA
    localparam logic [12:0] CV_BASE_MV = 13'h0fa0;
    localparam logic [12:0] CV_STEP_MV = 13'h0014;
    localparam logic [3:0] CV_LIN_MAX = 4'ha;
    localparam logic [12:0] CV_MV_D = 13'h107c;
    localparam logic [12:0] CV_MV_E = 13'h1090;
    localparam logic [12:0] CV_MV_F = 13'h109a;
    localparam logic [12:0] OVP_BASE_MV = 13'h1770;
    localparam logic [12:0] OVP_STEP_MV = 13'h01f4;
    localparam logic [9:0] LOW_RANGE_MA = 10'h05a;
    localparam logic [9:0] FAST_BASE_MA = 10'h0c8;
    localparam logic [9:0] FAST_STEP_MA = 10'h032;

    // Timing
    localparam int TMR_W = 44;
    localparam longint unsigned CLK_HZ = 64'h0ee6_b280;
    localparam longint unsigned PRE_TIMEOUT_MIN = 64'h1e;
    localparam longint unsigned AUTO_OFF_MIN = 64'h1e;
    localparam longint unsigned FAST_TIMEOUT_H0 = 64'h5;
    localparam longint unsigned FAST_TIMEOUT_H1 = 64'h6;
    localparam longint unsigned FAST_TIMEOUT_H2 = 64'h7;
    localparam logic [TMR_W-1:0] PRE_TIMEOUT_CYC = TMR_W'(PRE_TIMEOUT_MIN * 64'h3c * CLK_HZ);
    localparam logic [TMR_W-1:0] AUTO_OFF_CYC = TMR_W'(AUTO_OFF_MIN * 64'h3c * CLK_HZ);
    localparam logic [TMR_W-1:0] FAST_TIMEOUT0_CYC = TMR_W'(FAST_TIMEOUT_H0 * 64'he10 * CLK_HZ);
    localparam logic [TMR_W-1:0] FAST_TIMEOUT1_CYC = TMR_W'(FAST_TIMEOUT_H1 * 64'he10 * CLK_HZ);
    localparam logic [TMR_W-1:0] FAST_TIMEOUT2_CYC = TMR_W'(FAST_TIMEOUT_H2 * 64'he10 * CLK_HZ);
    localparam logic [1:0] FAST_TMR_OFF = 2'h3;

    typedef enum logic [2:0] {
        CHG_IDLE = 3'h0,
        CHG_PRE = 3'h1,
        CHG_FAST = 3'h3,
        CHG_CV = 3'h2,
        CHG_DONE = 3'h6,
        CHG_FAULT = 3'h7,
        CHG_STOP = 3'h5
    } chg_state_t;

endpackage : chg_pkg

`default_nettype wire

/* File: chg_evt_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface chg_evt_if;
    import chg_pkg::*;

    logic [NUM_EVT-1:0] set_evt;
    logic [NUM_EVT-1:0] mask;
    logic rd_clr;
    logic [NUM_EVT-1:0] flags;
    logic irq;

    modport owner (
        output set_evt,
        output mask,
        output rd_clr,
        input flags,
        input irq
    );

    modport bank (
        input set_evt,
        input mask,
        input rd_clr,
        output flags,
        output irq
    );

endinterface : chg_evt_if

`default_nettype wire

/* File: chg_evt_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module chg_evt_flags
    import chg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    chg_evt_if.bank evt
);

    logic [NUM_EVT-1:0] flags_ff;
    logic [NUM_EVT-1:0] nxt_flags;
    logic irq_ff;
    logic nxt_irq;

    genvar i;
    generate
        for (i = 0; i < NUM_EVT; i++)
        begin : g_flag
            // A new event in the clearing read's cycle survives the clear
            always_comb
            begin
                nxt_flags[i] = evt.set_evt[i] | (flags_ff[i] & ~evt.rd_clr);
            end
        end
    endgenerate

    always_comb
    begin
        nxt_irq = |(nxt_flags & ~evt.mask);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flags_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            irq_ff <= nxt_irq;
        end
    end

    assign evt.flags = flags_ff;
    assign evt.irq = irq_ff;

endmodule : chg_evt_flags

`default_nettype wire

/* File: chg_ctrl_regs.sv */
// What this block does
// - CV threshold in bits 3-0, reset 1010
// - CV code maps 4.00 V to 4.25 V
// - Bits 7-6 select 6.0-7.5 V overvoltage
// - Auto shutoff ends CV after 30 minutes
// - Range bit picks 90 mA or coded current
// - Current code 200 mA plus 50 mA steps
// - One event flag per state, stop shares the idle flag, top bits zero
// - Event flags clear on host read
// - Mask bits suppress event interrupts, reset unmasked
// - Fast timer expiry sets bit 7, stops charging
// - Pre-charge timer expiry sets bit 6, stops
// - Restart only on re-attach or override toggle
// - Bit 5 flags other charger faults
// - Bits 4-0 show present charge state
// - Enable override bit, reset 1
`timescale 1ns/1ps
`default_nettype none

module chg_ctrl_regs
    import chg_pkg::*;
#(
    parameter logic [TMR_W-1:0] PRE_TIMEOUT = chg_pkg::PRE_TIMEOUT_CYC,
    parameter logic [TMR_W-1:0] AUTO_OFF_TIMEOUT = chg_pkg::AUTO_OFF_CYC,
    parameter logic [TMR_W-1:0] FAST_TIMEOUT0 = chg_pkg::FAST_TIMEOUT0_CYC,
    parameter logic [TMR_W-1:0] FAST_TIMEOUT1 = chg_pkg::FAST_TIMEOUT1_CYC,
    parameter logic [TMR_W-1:0] FAST_TIMEOUT2 = chg_pkg::FAST_TIMEOUT2_CYC
)
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CHARGER_ATTACHED,
    input wire logic BAT_ABOVE_PRECHG,
    input wire logic BAT_AT_CV,
    input wire logic CHARGER_FAULT,
    output logic CHARGE_EN,
    output logic [2:0] CHARGE_STATE,
    output logic [12:0] CV_LEVEL_MV,
    output logic [12:0] OVP_LEVEL_MV,
    output logic [9:0] CURRENT_LIMIT_MA,
    output logic IRQ
);
    import chg_pkg::*;

    generate
        if (PRE_TIMEOUT == '0 || AUTO_OFF_TIMEOUT == '0 || FAST_TIMEOUT0 == '0
            || FAST_TIMEOUT1 == '0 || FAST_TIMEOUT2 == '0)
        begin : g_bad_timeout
            $error("chg_ctrl_regs: timeouts must be at least one cycle");
        end
    endgenerate

    function automatic logic [12:0] cv_code_to_mv(input logic [3:0] code);
        logic [12:0] mv;
        mv = CV_BASE_MV + CV_STEP_MV * {9'h000, code};
        case (code)
            4'hd: mv = CV_MV_D;
            4'he: mv = CV_MV_E;
            4'hf: mv = CV_MV_F;
            4'hb, 4'hc: mv = CV_BASE_MV + CV_STEP_MV * {9'h000, CV_LIN_MAX};
            default: mv = CV_BASE_MV + CV_STEP_MV * {9'h000, code};
        endcase
        return mv;
    endfunction : cv_code_to_mv

    // Pin synchronisers: the first stage feeds only the second
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic attached_prev_ff;
    logic attached_s;
    logic above_pre_s;
    logic at_cv_s;
    logic fault_s;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            attached_prev_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= {CHARGER_FAULT, BAT_AT_CV, BAT_ABOVE_PRECHG, CHARGER_ATTACHED};
            pin_s2_ff <= pin_s1_ff;
            attached_prev_ff <= pin_s2_ff[0];
        end
    end

    assign attached_s = pin_s2_ff[0];
    assign above_pre_s = pin_s2_ff[1];
    assign at_cv_s = pin_s2_ff[2];
    assign fault_s = pin_s2_ff[3];

    // Register file
    logic [7:0] ctrl1_ff;
    logic [7:0] volt_cfg_ff;
    logic [7:0] curr_cfg_ff;
    logic [5:0] masks_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_ctrl1;
    logic [7:0] nxt_volt_cfg;
    logic [7:0] nxt_curr_cfg;
    logic [5:0] nxt_masks;
    logic [7:0] nxt_rdata;
    logic [7:0] status_byte;
    logic fast_expired_ff;
    logic pre_expired_ff;

    chg_evt_if evt ();

    chg_evt_flags u_evt_flags (
        .clk(CLK),
        .srst(SRST),
        .evt(evt)
    );

    always_comb
    begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_volt_cfg = volt_cfg_ff;
        nxt_curr_cfg = curr_cfg_ff;
        nxt_masks = masks_ff;
        if (REG_WR)
        begin
            // Status and event flag registers ignore writes: they report hardware state
            if (REG_ADDR == CTRL1_OFS)
            begin
                nxt_ctrl1 = REG_WDATA;
            end
            else if (REG_ADDR == VOLT_CFG_OFS)
            begin
                nxt_volt_cfg = REG_WDATA;
            end
            else if (REG_ADDR == CURR_CFG_OFS)
            begin
                nxt_curr_cfg = REG_WDATA;
            end
            else if (REG_ADDR == EVT_MASKS_OFS)
            begin
                nxt_masks = REG_WDATA[5:0];
            end
        end
    end

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (REG_RD)
        begin
            if (REG_ADDR == CTRL1_OFS)
            begin
                nxt_rdata = ctrl1_ff;
            end
            else if (REG_ADDR == VOLT_CFG_OFS)
            begin
                nxt_rdata = volt_cfg_ff;
            end
            else if (REG_ADDR == CURR_CFG_OFS)
            begin
                nxt_rdata = curr_cfg_ff;
            end
            else if (REG_ADDR == EVT_FLAGS_OFS)
            begin
                nxt_rdata = {2'b00, evt.flags};
            end
            else if (REG_ADDR == EVT_MASKS_OFS)
            begin
                nxt_rdata = {2'b00, masks_ff};
            end
            else if (REG_ADDR == STATE_RPT_OFS)
            begin
                nxt_rdata = status_byte;
            end
        end
    end

    assign evt.rd_clr = REG_RD && (REG_ADDR == EVT_FLAGS_OFS);
    assign evt.mask = masks_ff;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ctrl1_ff <= CTRL1_RST;
            volt_cfg_ff <= VOLT_CFG_RST;
            curr_cfg_ff <= CURR_CFG_RST;
            masks_ff <= EVT_MASKS_RST;
            rdata_ff <= 8'h00;
        end
        else
        begin
            ctrl1_ff <= nxt_ctrl1;
            volt_cfg_ff <= nxt_volt_cfg;
            curr_cfg_ff <= nxt_curr_cfg;
            masks_ff <= nxt_masks;
            rdata_ff <= nxt_rdata;
        end
    end

    // Charge sequencer
    chg_state_t state_ff;
    chg_state_t nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;
    logic [TMR_W-1:0] tmr_lim;
    logic tmr_on;
    logic tmr_hit;
    logic ovr_prev_ff;
    logic nxt_fast_expired;
    logic nxt_pre_expired;
    logic enabled;
    logic restart;
    logic [5:0] nxt_set_evt;

    // Timeout shutdown is left only by a fresh attach or an override toggle
    assign restart = (attached_s & ~attached_prev_ff)
        | (ctrl1_ff[ENABLE_OVR_BIT] ^ ovr_prev_ff);
    assign enabled = ~ctrl1_ff[FORCE_DIS_BIT]
        & (ctrl1_ff[ENABLE_OVR_BIT] | attached_s);

    always_comb
    begin
        tmr_on = 1'b0;
        tmr_lim = PRE_TIMEOUT;
        case (state_ff)
            CHG_PRE:
            begin
                tmr_on = 1'b1;
                tmr_lim = PRE_TIMEOUT;
            end
            CHG_FAST:
            begin
                tmr_on = ctrl1_ff[FAST_TMR_LSB +: 2] != FAST_TMR_OFF;
                case (ctrl1_ff[FAST_TMR_LSB +: 2])
                    2'h0: tmr_lim = FAST_TIMEOUT0;
                    2'h1: tmr_lim = FAST_TIMEOUT1;
                    default: tmr_lim = FAST_TIMEOUT2;
                endcase
            end
            CHG_CV:
            begin
                tmr_on = curr_cfg_ff[AUTO_OFF_BIT];
                tmr_lim = AUTO_OFF_TIMEOUT;
            end
            default:
            begin
                tmr_on = 1'b0;
                tmr_lim = PRE_TIMEOUT;
            end
        endcase
        tmr_hit = tmr_on && (tmr_ff == tmr_lim - TMR_W'(1));
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_fast_expired = fast_expired_ff;
        nxt_pre_expired = pre_expired_ff;
        case (state_ff)
            CHG_IDLE:
            begin
                if (enabled)
                begin
                    nxt_state = CHG_PRE;
                end
            end
            CHG_PRE:
            begin
                if (tmr_hit)
                begin
                    nxt_state = CHG_STOP;
                    nxt_pre_expired = 1'b1;
                end
                else if (above_pre_s && ctrl1_ff[FAST_EN_BIT])
                begin
                    nxt_state = CHG_FAST;
                end
            end
            CHG_FAST:
            begin
                if (tmr_hit)
                begin
                    nxt_state = CHG_STOP;
                    nxt_fast_expired = 1'b1;
                end
                else if (at_cv_s)
                begin
                    nxt_state = CHG_CV;
                end
            end
            CHG_CV:
            begin
                if (tmr_hit)
                begin
                    nxt_state = CHG_DONE;
                end
            end
            CHG_DONE:
            begin
                nxt_state = CHG_DONE;
            end
            CHG_FAULT:
            begin
                if (!fault_s)
                begin
                    nxt_state = CHG_IDLE;
                end
            end
            CHG_STOP:
            begin
                if (restart)
                begin
                    nxt_state = CHG_IDLE;
                    nxt_fast_expired = 1'b0;
                    nxt_pre_expired = 1'b0;
                end
            end
            default:
            begin
                nxt_state = CHG_IDLE;
            end
        endcase
        // Disable and faults override sequencing, but a timeout shutdown holds
        if (state_ff != CHG_STOP)
        begin
            if (!enabled)
            begin
                nxt_state = CHG_IDLE;
            end
            else if (fault_s)
            begin
                nxt_state = CHG_FAULT;
            end
        end
        nxt_tmr = (nxt_state != state_ff || !tmr_on) ? '0 : tmr_ff + TMR_W'(1);
    end

    // Each state entry raises its event; shutdown reports as idle
    always_comb
    begin
        nxt_set_evt = 6'h00;
        if (nxt_state != state_ff)
        begin
            case (nxt_state)
                CHG_FAULT: nxt_set_evt[FAULT_EVT] = 1'b1;
                CHG_DONE: nxt_set_evt[DONE_EVT] = 1'b1;
                CHG_CV: nxt_set_evt[CV_EVT] = 1'b1;
                CHG_FAST: nxt_set_evt[FAST_EVT] = 1'b1;
                CHG_PRE: nxt_set_evt[PRE_EVT] = 1'b1;
                default: nxt_set_evt[IDLE_EVT] = 1'b1;
            endcase
        end
    end

    assign evt.set_evt = nxt_set_evt;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            state_ff <= CHG_IDLE;
            tmr_ff <= '0;
            fast_expired_ff <= 1'b0;
            pre_expired_ff <= 1'b0;
            ovr_prev_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            fast_expired_ff <= nxt_fast_expired;
            pre_expired_ff <= nxt_pre_expired;
            ovr_prev_ff <= ctrl1_ff[ENABLE_OVR_BIT];
        end
    end

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[FAST_EXPIRED_BIT] = fast_expired_ff;
        status_byte[PRE_EXPIRED_BIT] = pre_expired_ff;
        status_byte[FAULT_EVT] = state_ff == CHG_FAULT;
        status_byte[DONE_EVT] = state_ff == CHG_DONE;
        status_byte[CV_EVT] = state_ff == CHG_CV;
        status_byte[FAST_EVT] = state_ff == CHG_FAST;
        status_byte[PRE_EVT] = state_ff == CHG_PRE;
        status_byte[IDLE_EVT] = state_ff == CHG_IDLE || state_ff == CHG_STOP;
    end

    // Analog set points, registered so the loop sees clean steps
    logic [12:0] cv_mv_ff;
    logic [12:0] ovp_mv_ff;
    logic [9:0] ilim_ff;
    logic chg_en_ff;
    logic [12:0] nxt_cv_mv;
    logic [12:0] nxt_ovp_mv;
    logic [9:0] nxt_ilim;
    logic nxt_chg_en;

    always_comb
    begin
        nxt_cv_mv = cv_code_to_mv(volt_cfg_ff[CV_SEL_LSB +: 4]);
        nxt_ovp_mv = OVP_BASE_MV + OVP_STEP_MV * {11'h000, curr_cfg_ff[OVP_LSB +: 2]};
        if (curr_cfg_ff[RANGE_BIT])
        begin
            nxt_ilim = FAST_BASE_MA + FAST_STEP_MA * {6'h00, curr_cfg_ff[ISEL_LSB +: 4]};
        end
        else
        begin
            nxt_ilim = LOW_RANGE_MA;
        end
        nxt_chg_en = nxt_state == CHG_PRE || nxt_state == CHG_FAST || nxt_state == CHG_CV;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            cv_mv_ff <= 13'h0000;
            ovp_mv_ff <= 13'h0000;
            ilim_ff <= 10'h000;
            chg_en_ff <= 1'b0;
        end
        else
        begin
            cv_mv_ff <= nxt_cv_mv;
            ovp_mv_ff <= nxt_ovp_mv;
            ilim_ff <= nxt_ilim;
            chg_en_ff <= nxt_chg_en;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign CHARGE_EN = chg_en_ff;
    assign CHARGE_STATE = state_ff;
    assign CV_LEVEL_MV = cv_mv_ff;
    assign OVP_LEVEL_MV = ovp_mv_ff;
    assign CURRENT_LIMIT_MA = ilim_ff;
    assign IRQ = evt.irq;

endmodule : chg_ctrl_regs

`default_nettype wire

/* File: chg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module chg_host_model
(
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    // Idle address shows the inverse of the last address; wdata is inverted after a write and held across reads
    initial
    begin
        addr = 8'hff;
        wdata = 8'hff;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : write_reg

    // Reads of the event flags are destructive, so the host only reads on request
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        d = rdata;
    endtask : read_reg
endmodule : chg_host_model

`default_nettype wire

/* File: chg_ctrl_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module chg_ctrl_regs_chk
    import chg_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic CHARGE_EN,
    input wire logic [2:0] CHARGE_STATE,
    input wire logic [12:0] CV_LEVEL_MV,
    input wire logic [12:0] OVP_LEVEL_MV,
    input wire logic [9:0] CURRENT_LIMIT_MA,
    input wire logic IRQ
);
    logic [7:0] w_a_ff;
    logic [7:0] w_d_ff;
    logic [1:0] age_ff;
    // Set points are judged two edges after a write, once they have settled
    always_ff @(posedge CLK)
    begin
        if (SRST)
            age_ff <= 2'h0;
        else if (REG_WR)
        begin
            age_ff <= 2'h1;
            w_a_ff <= REG_ADDR;
            w_d_ff <= REG_WDATA;
        end
        else if (age_ff != 2'h0 && age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);
    sequence s_rd_at(logic [7:0] a);
        REG_RD && REG_ADDR == a;
    endsequence
    sequence s_settled(logic [7:0] a);
        age_ff == 2'h2 && w_a_ff == a;
    endsequence
    a_flag_top_zero: assert property (s_rd_at(8'h24) |=> REG_RDATA[7:6] == 2'h0)
        else $error("event flag upper bits not zero");
    a_mask_top_zero: assert property (s_rd_at(8'h25) |=> REG_RDATA[7:6] == 2'h0)
        else $error("event mask upper bits not zero");
    a_read_clears: assert property (s_rd_at(8'h24) ##0 !REG_WR |=> (!$stable(CHARGE_STATE) || !IRQ))
        else $error("interrupt stayed after flag read");
    a_status_fast: assert property (s_rd_at(8'h26) ##0 (CHARGE_STATE == CHG_FAST && $stable(CHARGE_STATE))
        |=> REG_RDATA[4:0] == 5'h04)
        else $error("status does not show fast charge");
    a_stop_no_charge: assert property (CHARGE_STATE == CHG_STOP |-> !CHARGE_EN)
        else $error("charging enabled after timer stop");
    a_run_charging: assert property (CHARGE_STATE inside {CHG_PRE, CHG_FAST, CHG_CV} |-> CHARGE_EN)
        else $error("charging off in a charging state");
    a_cv_level: assert property (s_settled(8'h21) ##0 w_d_ff[3:0] <= 4'ha
        |-> CV_LEVEL_MV == 13'h0fa0 + 13'h0014 * w_d_ff[3:0])
        else $error("constant voltage level wrong");
    a_cv_top: assert property (s_settled(8'h21) ##0 w_d_ff[3:0] == 4'hf |-> CV_LEVEL_MV == 13'h109a)
        else $error("top constant voltage level wrong");
    a_ovp_level: assert property (s_settled(8'h22) |-> OVP_LEVEL_MV == 13'h1770 + 13'h01f4 * w_d_ff[7:6])
        else $error("overvoltage level wrong");
    a_fast_range: assert property (s_settled(8'h22)
        |-> CURRENT_LIMIT_MA == (w_d_ff[4] ? 10'h0c8 + 10'h032 * w_d_ff[3:0] : 10'h05a))
        else $error("fast charge current wrong");
    a_mask_quiets: assert property (REG_WR && REG_ADDR == 8'h25 && REG_WDATA[5:0] == 6'h3f
        |-> ##2 !IRQ [*3])
        else $error("interrupt with all events masked");
endmodule : chg_ctrl_regs_chk

bind chg_ctrl_regs chg_ctrl_regs_chk u_chk (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CHARGE_EN(CHARGE_EN), .CHARGE_STATE(CHARGE_STATE),
    .CV_LEVEL_MV(CV_LEVEL_MV), .OVP_LEVEL_MV(OVP_LEVEL_MV), .CURRENT_LIMIT_MA(CURRENT_LIMIT_MA), .IRQ(IRQ));

`default_nettype wire

/* File: chg_ctrl_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module chg_ctrl_regs_tb;
    import chg_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [12:0] cv;
        logic [12:0] ov;
        logic [9:0] il;
    } chg_row_t;
    logic clk, srst, attached, above_pre, at_cv, fault, wr, rd, charge_en, irq;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] state;
    logic [12:0] cv_mv, ovp_mv;
    logic [9:0] ilim_ma;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    chg_row_t rows [10];

    // Short timers keep the run brief; the long waits below (40, 320 and 80 cycles) are sized from them
    chg_ctrl_regs #(.PRE_TIMEOUT(44'h12c), .AUTO_OFF_TIMEOUT(44'h01e), .FAST_TIMEOUT0(44'h03c),
        .FAST_TIMEOUT1(44'h046), .FAST_TIMEOUT2(44'h050)) uut (.CLK(clk), .SRST(srst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CHARGER_ATTACHED(attached),
        .BAT_ABOVE_PRECHG(above_pre), .BAT_AT_CV(at_cv), .CHARGER_FAULT(fault), .CHARGE_EN(charge_en),
        .CHARGE_STATE(state), .CV_LEVEL_MV(cv_mv), .OVP_LEVEL_MV(ovp_mv), .CURRENT_LIMIT_MA(ilim_ma), .IRQ(irq));
    chg_host_model u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares = compares + 1;
        if (s !== e)
        begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.read_reg(a, v);
        chk({8'h00, v}, {8'h00, e});
    endtask : rdc
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic rst();
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
    endtask : rst
    task automatic end_sim();
        $display("compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        {srst, attached, above_pre, at_cv, fault} = 5'h10;
        rows = '{'{8'h21, 8'h00, 13'h0fa0, 13'h1d4c, 10'h1c2}, '{8'h21, 8'h0a, 13'h1068, 13'h1d4c, 10'h1c2},
            '{8'h21, 8'h0d, 13'h107c, 13'h1d4c, 10'h1c2}, '{8'h21, 8'h0e, 13'h1090, 13'h1d4c, 10'h1c2},
            '{8'h21, 8'h0f, 13'h109a, 13'h1d4c, 10'h1c2}, '{8'h21, 8'h05, 13'h1004, 13'h1d4c, 10'h1c2},
            '{8'h22, 8'h00, 13'h1004, 13'h1770, 10'h05a}, '{8'h22, 8'h50, 13'h1004, 13'h1964, 10'h0c8},
            '{8'h22, 8'h9f, 13'h1004, 13'h1b58, 10'h3b6}, '{8'h22, 8'hf5, 13'h1004, 13'h1d4c, 10'h1c2}};
        rst();
        wt(4);
        chk(16'(cv_mv), 16'h1068);
        chk(16'(state), 16'(CHG_PRE));
        chk(16'(irq), 16'h0001);
        rdc(8'h25, 8'h00);
        rdc(8'h26, 8'h02);
        rdc(8'h24, 8'h02);
        chk(16'(irq), 16'h0000);
        rdc(8'h24, 8'h00);
        foreach (rows[i])
        begin
            u_host.write_reg(rows[i].a, rows[i].d);
            wt(2);
            chk(16'(cv_mv), 16'(rows[i].cv));
            chk(16'(ovp_mv), 16'(rows[i].ov));
            chk(16'(ilim_ma), 16'(rows[i].il));
            rdc(rows[i].a, rows[i].d);
        end
        // Masked event still latches its flag but keeps the interrupt low
        u_host.write_reg(8'h25, 8'hff);
        rdc(8'h25, 8'h3f);
        above_pre = 1'b1;
        wt(6);
        chk(16'(irq), 16'h0000);
        u_host.write_reg(8'h25, 8'h00);
        wt(2);
        chk(16'(irq), 16'h0001);
        rdc(8'h24, 8'h04);
        rdc(8'h26, 8'h04);
        at_cv = 1'b1;
        wt(6);
        rdc(8'h26, 8'h08);
        wt(40);
        rdc(8'h26, 8'h10);
        rdc(8'h24, 8'h18);
        fault = 1'b1;
        wt(6);
        rdc(8'h26, 8'h20);
        {fault, at_cv, above_pre} = 3'h0;
        wt(8);
        rdc(8'h24, 8'h23);
        wt(320);
        u_host.read_reg(8'h26, d);
        chk(16'(d[6]), 16'h0001);
        chk(16'(charge_en), 16'h0000);
        u_host.write_reg(8'h20, 8'h08);
        wt(6);
        u_host.read_reg(8'h26, d);
        chk(16'(d[6]), 16'h0000);
        chk(16'(charge_en), 16'h0000);
        attached = 1'b1;
        wt(6);
        chk(16'(charge_en), 16'h0001);
        above_pre = 1'b1;
        wt(80);
        u_host.read_reg(8'h26, d);
        chk(16'(d[7]), 16'h0001);
        chk(16'(charge_en), 16'h0000);
        attached = 1'b0;
        wt(6);
        chk(16'(state), 16'(CHG_STOP));
        attached = 1'b1;
        wt(8);
        u_host.read_reg(8'h26, d);
        chk(16'(d[7]), 16'h0000);
        chk(16'(charge_en), 16'h0001);
        u_host.write_reg(8'h24, 8'hff);
        rdc(8'h24, 8'h07);
        u_host.write_reg(8'h30, 8'hff);
        rdc(8'h30, 8'h00);
        u_host.write_reg(8'h26, 8'hff);
        rdc(8'h26, 8'h04);
        u_host.write_reg(8'h25, 8'h2a);
        rst();
        rdc(8'h21, 8'h1a);
        rdc(8'h22, 8'hd5);
        rdc(8'h25, 8'h00);
        end_sim();
    end
endmodule : chg_ctrl_regs_tb

`default_nettype wire
